// >>> rtl/ccrc_copy_ctrl.sv
`timescale 1ns/10ps
// Summary of operation
// - keep five saved configurations besides the running one
// - switch stores card configs per slot; modem holds its own sets
// - send copy to modem; update slot configs only after its success
// - copy onto running makes modem reinitialise, interrupting traffic
// - live card is updated only when destination is running
// - copy opcode 2C0DH with source and destination bytes 0 to 5
// - equal source and destination rejected with code 0x441
// - codes 0x440 bad source, 0x441 bad destination, 0x442 failure
// - uplink default power fault code is 0x43F
// - encoder selector codes 18 to 22 for modulator opcodes
// - decoder selector uses the same codes 18 to 22
// - alarm-5 mask bits 0..3 defined, bits 4..7 spare
// - alarm-5 status uses the mask's bit layout
// - demod status ends with spare byte and 4-byte symbol rate
// - sweep delay is two bytes in 0.1 second units, reserved
// - 2C0BH selects terminal emulation, codes 0 to 2
// - 2C0CH selects baud rate, codes 0 to 7
// - symbol pairing offered only while BPSK is selected
// - scrambler and descrambler compatible variants switch independently
module ccrc_copy_ctrl
  import ccrc_pkg::*;
#(
  parameter int NUM_SETS = 5,
  parameter int CARD_W = 32
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // modem command channel
  output ccrc_modem_cmd_t modem_cmd,
  input wire ccrc_modem_rsp_t modem_rsp,
  // modem status inputs
  input wire logic [7:0] rx_alarm_group5_status,
  input wire logic [31:0] rx_symbol_rate,
  // live interface card
  output logic [CARD_W-1:0] live_card_cfg,
  output logic live_card_load,
  output logic modem_reinit
);

  initial
  begin
    if (NUM_SETS != 5 || CARD_W < 1 || CARD_W > 32)
      $error("ccrc_copy_ctrl: unsupported parameters");
  end

  typedef enum logic [2:0] {
    CCRC_IDLE = 3'b001,
    CCRC_WAIT = 3'b010,
    CCRC_DONE = 3'b100
  } ccrc_state_t;

  ccrc_state_t state_reg;
  logic [7:0] src_reg;
  logic [7:0] dst_reg;
  logic [11:0] err_reg;
  logic busy_reg;
  logic [CARD_W-1:0] slot_cfg_reg [0:NUM_SETS];
  logic [7:0] modtype_reg;
  logic [7:0] enc_reg;
  logic [7:0] dec_reg;
  logic scr_v35_reg;
  logic dscr_v35_reg;
  logic pair_tx_reg;
  logic pair_rx_reg;
  logic [7:0] al5_mask_reg;
  logic [15:0] sweep_reg;
  logic [7:0] emul_reg;
  logic [7:0] baud_reg;
  logic [31:0] rd_next;
  logic wr_en;
  logic rd_err;
  logic wr_err;
  logic start_copy;
  logic [11:0] chk_err;
  logic [2:0] slot_idx;

  function automatic logic fec_ok(input logic [7:0] code);
    fec_ok = (code >= CCRC_FEC_TRELLIS_8_9) && (code <= CCRC_FEC_TURBO_325);
  endfunction : fec_ok

  function automatic logic cfg_ok(input logic [7:0] idx);
    cfg_ok = idx <= CCRC_CFG_LAST;
  endfunction : cfg_ok

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign start_copy = wr_en && paddr == CCRC_COPY_OFS && !busy_reg;
  assign slot_idx = paddr[4:2];

  // source checked first, then destination range and equality
  always_comb
  begin
    if (!cfg_ok(pwdata[7:0]))
      chk_err = CCRC_ERR_SRC;
    else if (!cfg_ok(pwdata[15:8]) || pwdata[7:0] == pwdata[15:8])
      chk_err = CCRC_ERR_DST;
    else
      chk_err = CCRC_ERR_NONE;
  end

  always_comb
  begin
    rd_err = 1'b0;
    rd_next = 32'h0000_0000;
    if (paddr >= CCRC_SLOTCFG_OFS && paddr < CCRC_SLOTCFG_OFS + 12'h018)
      rd_next = 32'(slot_cfg_reg[slot_idx]);
    else
    begin
      case (paddr)
        CCRC_COPY_OFS: rd_next = {16'h0000, dst_reg, src_reg};
        CCRC_STAT_OFS: rd_next = {19'h00000, busy_reg, err_reg};
        CCRC_MODCFG_OFS: rd_next = {5'h00, scr_v35_reg, pair_tx_reg, 1'b0,
                                    enc_reg, 8'h00, modtype_reg};
        CCRC_DEMCFG_OFS: rd_next = {5'h00, dscr_v35_reg, pair_rx_reg, 1'b0,
                                    dec_reg, sweep_reg};
        CCRC_ALARM_OFS: rd_next = {16'h0000,
                          rx_alarm_group5_status & CCRC_AL5_USED,
                          al5_mask_reg};
        CCRC_SYMRATE_OFS: rd_next = rx_symbol_rate;
        CCRC_TERM_OFS: rd_next = {16'h0000, baud_reg, emul_reg};
        CCRC_CTRL_OFS: rd_next = 32'h0000_0000;
        default: rd_err = 1'b1;
      endcase
    end
  end

  assign wr_err = wr_en && (rd_err || (paddr == CCRC_COPY_OFS && busy_reg));
  assign pslverr = psel && penable && (pwrite ? wr_err : rd_err);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_next;
  end

  // copy sequencer: modem first, switch state only on success
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= CCRC_IDLE;
      src_reg <= 8'h00;
      dst_reg <= 8'h00;
      err_reg <= CCRC_ERR_NONE;
      busy_reg <= 1'b0;
      modem_cmd <= '0;
    end
    else
    begin
      case (state_reg)
        CCRC_IDLE:
        begin
          if (start_copy)
          begin
            src_reg <= pwdata[7:0];
            dst_reg <= pwdata[15:8];
            err_reg <= chk_err;
            if (chk_err == CCRC_ERR_NONE)
            begin
              busy_reg <= 1'b1;
              modem_cmd <= '{1'b1, CCRC_OP_COPY, pwdata[7:0],
                             pwdata[15:8]};
              state_reg <= CCRC_WAIT;
            end
          end
        end
        CCRC_WAIT:
        begin
          modem_cmd.req <= 1'b0;
          if (modem_rsp.done)
          begin
            err_reg <= modem_rsp.ok ? CCRC_ERR_NONE
                                    : CCRC_ERR_GENERAL;
            state_reg <= CCRC_DONE;
          end
        end
        CCRC_DONE:
        begin
          busy_reg <= 1'b0;
          state_reg <= CCRC_IDLE;
        end
        default: state_reg <= CCRC_IDLE;
      endcase
    end
  end

  // slot store; index 0 mirrors the running card, but APB writes to index 0 do not load the live card
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i <= NUM_SETS; i++)
        slot_cfg_reg[i] <= '0;
    end
    else if (state_reg == CCRC_WAIT && modem_rsp.done && modem_rsp.ok)
      slot_cfg_reg[dst_reg[2:0]] <= slot_cfg_reg[src_reg[2:0]];
    else if (wr_en && !busy_reg && paddr >= CCRC_SLOTCFG_OFS
             && paddr < CCRC_SLOTCFG_OFS + 12'h018)
      slot_cfg_reg[slot_idx] <= pwdata[CARD_W-1:0];
  end

  // live card touched only by a successful copy onto running
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      live_card_cfg <= '0;
      live_card_load <= 1'b0;
      modem_reinit <= 1'b0;
    end
    else
    begin
      live_card_load <= 1'b0;
      modem_reinit <= 1'b0;
      if (state_reg == CCRC_WAIT && modem_rsp.done && modem_rsp.ok
          && dst_reg == CCRC_CFG_RUNNING)
      begin
        live_card_cfg <= slot_cfg_reg[src_reg[2:0]];
        live_card_load <= 1'b1;
        modem_reinit <= 1'b1;
      end
    end
  end

  // modem settings; bad codes leave the old value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      modtype_reg <= CCRC_MODTYPE_RST;
      enc_reg <= CCRC_FEC_RST;
      dec_reg <= CCRC_FEC_RST;
      scr_v35_reg <= 1'b0;
      dscr_v35_reg <= 1'b0;
      pair_tx_reg <= 1'b0;
      pair_rx_reg <= 1'b0;
      al5_mask_reg <= CCRC_AL5_MASK_RST;
      sweep_reg <= CCRC_SWEEP_RST;
      emul_reg <= CCRC_EMUL_RST;
      baud_reg <= CCRC_BAUD_RST;
    end
    else
    begin
      if (modtype_reg != CCRC_MOD_BPSK)
      begin
        pair_tx_reg <= 1'b0;
        pair_rx_reg <= 1'b0;
      end
      if (wr_en && paddr == CCRC_MODCFG_OFS)
      begin
        modtype_reg <= pwdata[7:0];
        if (fec_ok(pwdata[23:16]))
          enc_reg <= pwdata[23:16];
        pair_tx_reg <= pwdata[25]
                       && pwdata[7:0] == CCRC_MOD_BPSK;
        scr_v35_reg <= pwdata[26];
      end
      if (wr_en && paddr == CCRC_DEMCFG_OFS)
      begin
        sweep_reg <= pwdata[15:0];
        if (fec_ok(pwdata[23:16]))
          dec_reg <= pwdata[23:16];
        pair_rx_reg <= pwdata[25]
                       && modtype_reg == CCRC_MOD_BPSK;
        dscr_v35_reg <= pwdata[26];
      end
      if (wr_en && paddr == CCRC_ALARM_OFS)
        al5_mask_reg <= pwdata[7:0] & CCRC_AL5_USED;
      if (wr_en && paddr == CCRC_TERM_OFS)
      begin
        if (pwdata[7:0] <= CCRC_EMUL_LAST)
          emul_reg <= pwdata[7:0];
        if (pwdata[15:8] <= CCRC_BAUD_LAST)
          baud_reg <= pwdata[15:8];
      end
    end
  end

  // uplink power fault code is only reported by the modem, kept for decode
  logic unused_ok;
  assign unused_ok = &{CCRC_ERR_UPLINK_POWER == 12'h43F};

endmodule : ccrc_copy_ctrl

// >>> rtl/ccrc_pkg.sv
package ccrc_pkg;

  // register byte offsets
  localparam logic [11:0] CCRC_CTRL_OFS = 12'h000;
  localparam logic [11:0] CCRC_COPY_OFS = 12'h004;
  localparam logic [11:0] CCRC_STAT_OFS = 12'h008;
  localparam logic [11:0] CCRC_MODEM_OFS = 12'h00C;
  localparam logic [11:0] CCRC_MODCFG_OFS = 12'h010;
  localparam logic [11:0] CCRC_DEMCFG_OFS = 12'h014;
  localparam logic [11:0] CCRC_ALARM_OFS = 12'h018;
  localparam logic [11:0] CCRC_SYMRATE_OFS = 12'h01C;
  localparam logic [11:0] CCRC_TERM_OFS = 12'h020;
  localparam logic [11:0] CCRC_SLOTCFG_OFS = 12'h040;
  localparam logic [11:0] CCRC_LIVECFG_OFS = 12'h060;

  // opcodes and codes
  localparam logic [15:0] CCRC_OP_COPY = 16'h2C0D;
  localparam logic [15:0] CCRC_OP_EMUL = 16'h2C0B;
  localparam logic [15:0] CCRC_OP_BAUD = 16'h2C0C;
  localparam logic [15:0] CCRC_OP_MOD_A = 16'h2400;
  localparam logic [15:0] CCRC_OP_MOD_B = 16'h2607;
  localparam logic [15:0] CCRC_OP_DEM_A = 16'h2401;
  localparam logic [15:0] CCRC_OP_DEM_B = 16'h2409;
  localparam logic [15:0] CCRC_OP_DEM_C = 16'h2A08;
  localparam logic [15:0] CCRC_OP_DEM_STAT = 16'h240C;
  localparam logic [11:0] CCRC_ERR_NONE = 12'h000;
  localparam logic [11:0] CCRC_ERR_UPLINK_POWER = 12'h43F;
  localparam logic [11:0] CCRC_ERR_SRC = 12'h440;
  localparam logic [11:0] CCRC_ERR_DST = 12'h441;
  localparam logic [11:0] CCRC_ERR_GENERAL = 12'h442;

  // configuration indices
  localparam logic [7:0] CCRC_CFG_RUNNING = 8'h00;
  localparam logic [7:0] CCRC_CFG_LAST = 8'h05;

  // encoder / decoder selector codes
  localparam logic [7:0] CCRC_FEC_TRELLIS_8_9 = 8'h12;
  localparam logic [7:0] CCRC_FEC_LEGACY_SEQ_3_4 = 8'h13;
  localparam logic [7:0] CCRC_FEC_TURBO_793 = 8'h14;
  localparam logic [7:0] CCRC_FEC_TURBO_495 = 8'h15;
  localparam logic [7:0] CCRC_FEC_TURBO_325 = 8'h16;

  // alarm group 5 bit positions
  localparam int CCRC_AL5_TRELLIS_LOCK = 0;
  localparam int CCRC_AL5_FMDSP_LOCK = 1;
  localparam int CCRC_AL5_T1_SIG_FAULT = 2;
  localparam int CCRC_AL5_TURBO_LOCK = 3;
  localparam logic [7:0] CCRC_AL5_USED = 8'h0F;

  // modulation, terminal codes
  localparam logic [7:0] CCRC_MOD_BPSK = 8'h00;
  localparam logic [7:0] CCRC_EMUL_LAST = 8'h02;
  localparam logic [7:0] CCRC_BAUD_LAST = 8'h07;
  localparam logic [15:0] CCRC_SWEEP_UNIT_MS = 16'h0064;

  // reset values
  localparam logic [7:0] CCRC_MODTYPE_RST = 8'h00;
  localparam logic [7:0] CCRC_FEC_RST = 8'h12;
  localparam logic [7:0] CCRC_AL5_MASK_RST = 8'h00;
  localparam logic [7:0] CCRC_EMUL_RST = 8'h00;
  localparam logic [7:0] CCRC_BAUD_RST = 8'h05;
  localparam logic [15:0] CCRC_SWEEP_RST = 16'h0000;

  typedef struct packed {
    logic req;
    logic [15:0] opcode;
    logic [7:0] arg0;
    logic [7:0] arg1;
  } ccrc_modem_cmd_t;

  typedef struct packed {
    logic done;
    logic ok;
  } ccrc_modem_rsp_t;

endpackage : ccrc_pkg

// >>> tb/ccrc_copy_ctrl_assertions.sv
`timescale 1ns/10ps
module ccrc_copy_ctrl_chk
  import ccrc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // modem and card
  input wire ccrc_modem_cmd_t modem_cmd,
  input wire ccrc_modem_rsp_t modem_rsp,
  input wire logic [7:0] rx_alarm_group5_status,
  input wire logic [31:0] rx_symbol_rate,
  input wire logic live_card_load,
  input wire logic modem_reinit
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic rd_setup;
  assign rd_setup = psel && !penable && !pwrite;
  property p_op;
    modem_cmd.req |-> modem_cmd.opcode == CCRC_OP_COPY;
  endproperty
  a_op: assert property (p_op)
    else $error("copy opcode wrong");
  property p_diff;
    modem_cmd.req |-> modem_cmd.arg0 != modem_cmd.arg1;
  endproperty
  a_diff: assert property (p_diff)
    else $error("equal indices sent to modem");
  property p_range;
    modem_cmd.req |-> modem_cmd.arg0 <= CCRC_CFG_LAST &&
      modem_cmd.arg1 <= CCRC_CFG_LAST;
  endproperty
  a_range: assert property (p_range)
    else $error("index out of range sent");
  property p_pulse;
    modem_cmd.req |=> !modem_cmd.req;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("request longer than a cycle");
  property p_ld;
    live_card_load |-> $past(modem_rsp.done && modem_rsp.ok) &&
      modem_cmd.arg1 == CCRC_CFG_RUNNING;
  endproperty
  a_ld: assert property (p_ld)
    else $error("card loaded without good copy");
  property p_run;
    modem_rsp.done && modem_rsp.ok && modem_cmd.arg1 == CCRC_CFG_RUNNING
      |=> live_card_load && modem_reinit;
  endproperty
  a_run: assert property (p_run)
    else $error("running copy not applied");
  property p_rei;
    modem_reinit |-> live_card_load;
  endproperty
  a_rei: assert property (p_rei)
    else $error("reinit without card load");
  property p_al;
    rd_setup && paddr == CCRC_ALARM_OFS |=> prdata[15:4] ==
      {4'h0, $past(rx_alarm_group5_status[3:0]), 4'h0};
  endproperty
  a_al: assert property (p_al)
    else $error("alarm status read wrong");
  property p_sym;
    rd_setup && paddr == CCRC_SYMRATE_OFS |=> prdata == $past(rx_symbol_rate);
  endproperty
  a_sym: assert property (p_sym)
    else $error("symbol rate read wrong");
  c_req: cover property (modem_cmd.req);
  c_ld: cover property (live_card_load);
  c_al: cover property (rd_setup && paddr == CCRC_ALARM_OFS);
endmodule : ccrc_copy_ctrl_chk

// >>> tb/ccrc_copy_ctrl_tb.sv
`timescale 1ns/10ps
module ccrc_copy_ctrl_tb;
  import ccrc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, rx_symbol_rate = '0, live_card_cfg;
  logic pready, pslverr, live_card_load, modem_reinit, fail = 0, se, f, lv;
  logic [3:0] dly = '0;
  logic [7:0] rx_alarm_group5_status = '0, s, t;
  logic [11:0] e;
  logic [31:0] m [6];
  ccrc_modem_cmd_t modem_cmd;
  ccrc_modem_rsp_t modem_rsp;
  int error_cnt = 0, compares = 0;
  ccrc_copy_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .modem_cmd, .modem_rsp,
    .rx_alarm_group5_status, .rx_symbol_rate, .live_card_cfg,
    .live_card_load, .modem_reinit);
  ccrc_modem_model modem_u (.pclk, .presetn, .modem_cmd, .modem_rsp,
    .fail, .dly);
  initial
    forever #4 pclk = ~pclk;
  task automatic close_out;
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] x, g);
    compares++;
    if (g !== x)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wt;
    do apb(1'b0, CCRC_STAT_OFS, 0); while (rd[12] !== 1'b0);
  endtask : wt
  function automatic logic [11:0] exp_err(input logic [7:0] a, b, input logic x);
    if (a > CCRC_CFG_LAST)
      return CCRC_ERR_SRC;
    if (b > CCRC_CFG_LAST || a == b)
      return CCRC_ERR_DST;
    return x ? CCRC_ERR_GENERAL : CCRC_ERR_NONE;
  endfunction : exp_err
  initial
  begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
  initial
  begin
    void'($urandom(32'hC88CEC12));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    lv = 1'b0;
    apb(1'b0, CCRC_TERM_OFS, 0);
    chk("term", 32'h0500, rd & 32'hFFFF);
    apb(1'b0, CCRC_MODEM_OFS, 0);
    chk("slverr", 1, 32'(se));
    for (int i = 0; i < 6; i++)
    begin
      m[i] = $urandom;
      apb(1'b1, CCRC_SLOTCFG_OFS + 12'(4 * i), m[i]);
    end
    dly <= 4'hF;
    apb(1'b1, CCRC_COPY_OFS, 32'h0201);
    apb(1'b1, CCRC_COPY_OFS, 32'h0403);
    chk("busy", 1, 32'(se));
    wt();
    m[2] = m[1];
    for (int i = 0; i < 16; i++)
    begin
      s = (i == 0) ? 8'h06 : 8'($urandom_range(5));
      t = (i == 1) ? 8'h09 : (i == 2) ? s : 8'($urandom_range(5));
      f = 1'($urandom_range(1));
      fail <= f;
      dly <= 4'($urandom);
      apb(1'b1, CCRC_COPY_OFS, {16'h0, t, s});
      wt();
      e = exp_err(s, t, f);
      chk("err", 32'(e), rd & 32'hFFF);
      if (e == CCRC_ERR_NONE)
        m[t[2:0]] = m[s[2:0]];
      if (e == CCRC_ERR_NONE && t == 0)
        lv = 1'b1;
      if (t <= CCRC_CFG_LAST)
        apb(1'b0, CCRC_SLOTCFG_OFS + 12'(4 * t), 0);
      if (t <= CCRC_CFG_LAST)
        chk("slot", m[t[2:0]], rd);
      if (lv)
        chk("live", m[0], live_card_cfg);
    end
    for (int c = 18; c < 24; c++)
    begin
      s = 8'(c);
      e = 12'($urandom);
      apb(1'b1, CCRC_MODCFG_OFS, {8'h0, s, 16'h0});
      apb(1'b1, CCRC_DEMCFG_OFS, {8'h0, s, 4'h0, e});
      apb(1'b0, CCRC_MODCFG_OFS, 0);
      chk("enc", (c > 22) ? 22 : c, 32'(rd[23:16]));
      apb(1'b0, CCRC_DEMCFG_OFS, 0);
      chk("dec", (c > 22) ? 22 : c, 32'(rd[23:16]));
      chk("sweep", 32'(e), 32'(rd[15:0]));
    end
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, CCRC_MODCFG_OFS, 32'h06120000 | i);
      apb(1'b0, CCRC_MODCFG_OFS, 0);
      chk("pair", {1'b1, i == 0}, 32'(rd[26:25]));
    end
    for (int i = 0; i < 25; i++)
    begin
      apb(1'b1, CCRC_TERM_OFS, 32'(i % 8 * 256 + i / 8));
      apb(1'b0, CCRC_TERM_OFS, 0);
      chk("term", (i < 24) ? 32'(i % 8 * 256 + i / 8) : 32'h0002,
          rd & 32'hFFFF);
    end
    rx_alarm_group5_status <= 8'($urandom);
    rx_symbol_rate <= $urandom;
    apb(1'b1, CCRC_ALARM_OFS, 32'hFF);
    apb(1'b0, CCRC_ALARM_OFS, 0);
    chk("alarm", {20'h0, rx_alarm_group5_status[3:0], 8'h0F}, rd & 32'hFFFF);
    apb(1'b0, CCRC_SYMRATE_OFS, 0);
    chk("symrate", rx_symbol_rate, rd);
    close_out();
  end
endmodule : ccrc_copy_ctrl_tb
bind ccrc_copy_ctrl ccrc_copy_ctrl_chk chk_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .modem_cmd, .modem_rsp,
  .rx_alarm_group5_status, .rx_symbol_rate, .live_card_load, .modem_reinit);

// >>> tb/ccrc_modem_model.sv
`timescale 1ns/10ps
module ccrc_modem_model
  import ccrc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command channel
  input wire ccrc_modem_cmd_t modem_cmd,
  output ccrc_modem_rsp_t modem_rsp,
  // scenario control
  input wire logic fail,
  input wire logic [3:0] dly
);
  logic [4:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= '0;
      modem_rsp <= '0;
    end
    else
    begin
      modem_rsp <= '0;
      if (modem_cmd.req && modem_cmd.opcode == CCRC_OP_COPY)
        cnt_reg <= {1'b0, dly} + 5'h1;
      else if (cnt_reg == 5'h1)
      begin
        cnt_reg <= '0;
        modem_rsp <= {1'b1, !fail};
      end
      else if (cnt_reg != '0)
        cnt_reg <= cnt_reg - 5'h1;
    end
  end
endmodule : ccrc_modem_model
